/* File: design/prcr_pkg.sv */
// Constants shared by the ramp and input configuration register bank.
// Assumes byte-wide registers behind the serial management port decoder.
package prcr_pkg;

    // ----------------------------------------------------------------
    // Register access port
    // ----------------------------------------------------------------
    localparam int ADDR_W = 16;                    // Register address width
    localparam int DATA_W = 8;                     // Register data width

    // ----------------------------------------------------------------
    // Register byte addresses
    // ----------------------------------------------------------------
    localparam logic [15:0] RAMP_CONTROL_D_ADDR      = 16'h07A6;
    localparam logic [15:0] LOOP_LIMIT_CONFIG_D_ADDR = 16'h07AC;
    localparam logic [15:0] ITERATION_LIMIT_D_LO     = 16'h07AD;
    localparam logic [15:0] ITERATION_LIMIT_D_HI     = 16'h07AE;
    localparam logic [15:0] SETTLE_TARGET_D_LO       = 16'h07B1;
    localparam logic [15:0] SETTLE_TARGET_D_HI       = 16'h07B2;
    localparam logic [15:0] EXT_OSC_SOURCE_ADDR      = 16'h090E;
    localparam logic [15:0] IO_LEVEL_CONFIG_ADDR     = 16'h0943;
    localparam logic [15:0] INPUT_BUFFER_CONFIG_ADDR = 16'h0949;
    localparam logic [15:0] INPUT_DETECTOR_EN_ADDR   = 16'h094A;
    localparam logic [15:0] INPUT_HYSTERESIS_LO      = 16'h094E;
    localparam logic [15:0] INPUT_HYSTERESIS_HI      = 16'h094F;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int RAMP_SCALE_LSB    = 0;          // ramp_scale_d [2:0]
    localparam int RAMP_SWITCH_BIT   = 3;          // ramped_switch_on_d
    localparam int CEILING_BIT       = 0;          // output_ceiling_on_d
    localparam int SETTLE_DET_BIT    = 3;          // settle_detect_on_d
    localparam int NUM_INPUTS        = 4;          // Clock inputs
    localparam int PULSED_LSB        = 4;          // Pulsed format [7:4]
    localparam int HYST_W            = 12;         // input_hysteresis_cfg

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [3:0]  RAMP_CONTROL_RST  = 4'h0;
    localparam logic [1:0]  LOOP_LIMIT_RST    = 2'h0;
    localparam logic [15:0] ITER_CAP_RST      = 16'h0000;
    localparam logic [15:0] SETTLE_GOAL_RST   = 16'h0000;
    localparam logic        EXT_OSC_RST       = 1'b0;
    localparam logic        IO_LEVEL_RST      = 1'b0;  // 1.8 V levels
    localparam logic [7:0]  INPUT_CFG_RST     = 8'h00;
    localparam logic [3:0]  DETECTOR_EN_RST   = 4'h0;
    localparam logic [11:0] HYST_RST          = 12'h000;

    // ----------------------------------------------------------------
    // Ramp rate arithmetic
    // ----------------------------------------------------------------
    localparam int SCALE_W     = 3;                // Step scaling code
    localparam int BASE_RATE_W = 8;                // Base ramp rate width
    localparam int FRAC_W      = 2;                // Fraction bits of result
    localparam int RATE_W      = BASE_RATE_W + 10 + FRAC_W;

    // Step scaling codes
    localparam logic [2:0] SCALE_X1     = 3'h0;
    localparam logic [2:0] SCALE_X4     = 3'h1;
    localparam logic [2:0] SCALE_X16    = 3'h2;
    localparam logic [2:0] SCALE_X64    = 3'h3;
    localparam logic [2:0] SCALE_X256   = 3'h4;
    localparam logic [2:0] SCALE_X1024  = 3'h5;
    localparam logic [2:0] SCALE_QUART  = 3'h6;
    localparam logic [2:0] SCALE_HALF   = 3'h7;

endpackage

/* File: design/prcr_cfg_if.sv */
// Carries configuration from the register bank to its helper modules.
// Assumes all parties run on the same clock.
`timescale 1ns/1ns
interface prcr_cfg_if;
    import prcr_pkg::*;

    logic [SCALE_W-1:0]     rampScaleD;      // Step scaling code
    logic [BASE_RATE_W-1:0] baseRampRateD;   // Base holdover ramp rate
    logic [RATE_W-1:0]      rampRateD;       // Final rate, 2 fraction bits
    logic [7:0]             inputCfg;        // Buffer enables and formats
    logic [3:0]             detectorCfg;     // Input to detector enables
    logic [3:0]             bufferOn;        // Powered input buffers
    logic [3:0]             pulsedCmos;      // Pulsed format selects
    logic [3:0]             detectorOn;      // Effective detector feeds

    // Register bank side
    modport bank (output rampScaleD, output baseRampRateD, output inputCfg,
                  output detectorCfg, input rampRateD, input bufferOn,
                  input pulsedCmos, input detectorOn);
    // Ramp scaler side
    modport ramp (input rampScaleD, input baseRampRateD, output rampRateD);
    // Input control side
    modport inp  (input inputCfg, input detectorCfg, output bufferOn,
                  output pulsedCmos, output detectorOn);
endinterface

/* File: design/prcr_ramp_scale.sv */
// Final ramp rate: base rate times the decoded step scaling factor.
// Assumes base rate and code come from logic on the same clock.
`timescale 1ns/1ns
module prcr_ramp_scale
    import prcr_pkg::*;
(
    input  wire logic clk,
    input  wire logic reset,
    prcr_cfg_if.ramp  cfg
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [RATE_W-1:0] rate;                  // Registered product
    } prcr_ramp_s;

    prcr_ramp_s state_r;                          // Current state
    prcr_ramp_s state_nxt;                        // Next state
    logic [RATE_W-1:0] baseFix;                   // Base with fraction bits

    // Base rate widened; two fraction bits let 1/4x stay exact
    assign baseFix = RATE_W'({cfg.baseRampRateD, 2'b00});

    // Decode the code into a shift: powers of four, or a quarter or half
    always_comb begin
        state_nxt = state_r;
        case (cfg.rampScaleD)
            SCALE_X1:    state_nxt.rate = baseFix;
            SCALE_X4:    state_nxt.rate = baseFix << 2;
            SCALE_X16:   state_nxt.rate = baseFix << 4;
            SCALE_X64:   state_nxt.rate = baseFix << 6;
            SCALE_X256:  state_nxt.rate = baseFix << 8;
            SCALE_X1024: state_nxt.rate = baseFix << 10;
            SCALE_QUART: state_nxt.rate = baseFix >> 2;
            default:     state_nxt.rate = baseFix >> 1;
        endcase
    end

    // Register the product
    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign cfg.rampRateD = state_r.rate;

endmodule // prcr_ramp_scale

/* File: design/prcr_input_ctrl.sv */
// Per-input buffer power, format select and detector feed.
// Assumes configuration bits come from the register bank on this clock.
`timescale 1ns/1ns
module prcr_input_ctrl
    import prcr_pkg::*;
(
    input  wire logic clk,
    input  wire logic reset,
    prcr_cfg_if.inp   cfg
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [3:0] bufferOn;                     // Buffer powered
        logic [3:0] pulsedCmos;                   // Pulsed format chosen
        logic [3:0] detectorOn;                   // Feed to phase detector
    } prcr_inp_s;

    prcr_inp_s  state_r;                          // Current state
    prcr_inp_s  state_nxt;                        // Next state
    logic [3:0] feedOk;                           // Per-input feed gate

    // A powered-down input cannot feed the detector
    for (genvar n = 0; n < NUM_INPUTS; n++) begin : g_input
        assign feedOk[n] = cfg.detectorCfg[n] & cfg.inputCfg[n];
    end

    // Split the input configuration byte
    always_comb begin
        state_nxt            = state_r;
        state_nxt.bufferOn   = cfg.inputCfg[NUM_INPUTS-1:0];
        state_nxt.pulsedCmos = cfg.inputCfg[PULSED_LSB+:NUM_INPUTS];
        state_nxt.detectorOn = feedOk;
    end

    // Register the decoded controls
    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign cfg.bufferOn   = state_r.bufferOn;
    assign cfg.pulsedCmos = state_r.pulsedCmos;
    assign cfg.detectorOn = state_r.detectorOn;

endmodule // prcr_input_ctrl

/* File: design/prcr_regs.sv */
// Register bank for the fourth loop's ramp control and the device-wide
// input page. Assumes a serial port decoder that presents byte-wide
// single-cycle read and write strobes on this clock.
`timescale 1ns/1ns
module prcr_regs
    import prcr_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   reset,
    input  wire logic [ADDR_W-1:0]      regAddr,
    input  wire logic                   regWrEn,
    input  wire logic [DATA_W-1:0]      regWrData,
    input  wire logic                   regRdEn,
    output logic      [DATA_W-1:0]      regRdData,
    output logic                        regRdValid,
    input  wire logic [BASE_RATE_W-1:0] baseRampRateD,
    output logic      [RATE_W-1:0]      rampRateD,
    output logic                        inputSwitchRampedD,
    output logic                        holdoverEntryRampedD,
    output logic                        outputCeilingOnD,
    output logic                        settleDetectOnD,
    output logic      [15:0]            iterationCapD,
    output logic      [15:0]            settleGoalD,
    output logic                        extOscSelect,
    output logic                        ioLevel33,
    output logic      [3:0]             inputBufferOn,
    output logic      [3:0]             inputPulsedCmos,
    output logic      [3:0]             inputToDetectorOn,
    output logic      [HYST_W-1:0]      inputHysteresisCfg
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [3:0]        rampControl;           // Scale code and enable
        logic              ceilingOn;             // Output ceiling enable
        logic              settleDetOn;           // Settle detect enable
        logic [15:0]       iterationCap;          // Iteration limit
        logic [15:0]       settleGoal;            // Settle target
        logic              extOsc;                // Oscillator source
        logic              ioLevel;               // I/O threshold select
        logic [7:0]        inputCfg;              // Buffer enable, format
        logic [3:0]        detectorCfg;           // Input to detector
        logic [HYST_W-1:0] hysteresis;            // Hysteresis setting
        logic [DATA_W-1:0] rdData;                // Read answer
        logic              rdValid;               // Read answer strobe
    } prcr_regs_s;

    prcr_regs_s state_r;                          // Current state
    prcr_regs_s state_nxt;                        // Next state

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    prcr_cfg_if cfgBus ();                        // Link to helper modules

    // Feed the helpers from the stored settings and the base rate input port
    assign cfgBus.rampScaleD    = state_r.rampControl[RAMP_SCALE_LSB+:SCALE_W];
    assign cfgBus.baseRampRateD = baseRampRateD;
    assign cfgBus.inputCfg      = state_r.inputCfg;
    assign cfgBus.detectorCfg   = state_r.detectorCfg;

    // Base rate times step factor
    prcr_ramp_scale u_ramp_scale (
        .clk   (clk),
        .reset (reset),
        .cfg   (cfgBus.ramp)
    );

    // Per-input buffer and format controls
    prcr_input_ctrl u_input_ctrl (
        .clk   (clk),
        .reset (reset),
        .cfg   (cfgBus.inp)
    );

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    // Writes land in one cycle; reads answer one cycle after the strobe.
    // A read and write of the same address in one cycle returns the old
    // value, which keeps the read path free of the write data mux.
    always_comb begin
        state_nxt         = state_r;
        state_nxt.rdValid = 1'b0;

        // Write decode; bits with no field are dropped
        if (regWrEn) begin
            if (regAddr == RAMP_CONTROL_D_ADDR) begin
                // Scale code and ramped switching enable
                state_nxt.rampControl = regWrData[3:0];
            end else if (regAddr == LOOP_LIMIT_CONFIG_D_ADDR) begin
                // Two independent loop options
                state_nxt.ceilingOn   = regWrData[CEILING_BIT];
                state_nxt.settleDetOn = regWrData[SETTLE_DET_BIT];
            end else if (regAddr == ITERATION_LIMIT_D_LO) begin
                // Low byte of the iteration limit
                state_nxt.iterationCap[7:0] = regWrData;
            end else if (regAddr == ITERATION_LIMIT_D_HI) begin
                // High byte of the iteration limit
                state_nxt.iterationCap[15:8] = regWrData;
            end else if (regAddr == SETTLE_TARGET_D_LO) begin
                // Low byte of the settle target
                state_nxt.settleGoal[7:0] = regWrData;
            end else if (regAddr == SETTLE_TARGET_D_HI) begin
                // High byte of the settle target
                state_nxt.settleGoal[15:8] = regWrData;
            end else if (regAddr == EXT_OSC_SOURCE_ADDR) begin
                // Stored as written; holding it at one is the host's job
                state_nxt.extOsc = regWrData[0];
            end else if (regAddr == IO_LEVEL_CONFIG_ADDR) begin
                // Threshold select; a 3.3 V host writes this first
                state_nxt.ioLevel = regWrData[0];
            end else if (regAddr == INPUT_BUFFER_CONFIG_ADDR) begin
                // Enables in the low nibble, formats in the high
                state_nxt.inputCfg = regWrData;
            end else if (regAddr == INPUT_DETECTOR_EN_ADDR) begin
                // Per-input detector feed
                state_nxt.detectorCfg = regWrData[3:0];
            end else if (regAddr == INPUT_HYSTERESIS_LO) begin
                // Low byte of the hysteresis setting
                state_nxt.hysteresis[7:0] = regWrData;
            end else if (regAddr == INPUT_HYSTERESIS_HI) begin
                // Only the low nibble belongs to this field
                state_nxt.hysteresis[HYST_W-1:8] = regWrData[3:0];
            end
        end

        // Read decode; unmapped addresses answer zero
        if (regRdEn) begin
            state_nxt.rdValid = 1'b1;
            if (regAddr == RAMP_CONTROL_D_ADDR) begin
                state_nxt.rdData = {4'h0, state_r.rampControl};
            end else if (regAddr == LOOP_LIMIT_CONFIG_D_ADDR) begin
                state_nxt.rdData = {4'h0, state_r.settleDetOn, 2'h0,
                                    state_r.ceilingOn};
            end else if (regAddr == ITERATION_LIMIT_D_LO) begin
                state_nxt.rdData = state_r.iterationCap[7:0];
            end else if (regAddr == ITERATION_LIMIT_D_HI) begin
                state_nxt.rdData = state_r.iterationCap[15:8];
            end else if (regAddr == SETTLE_TARGET_D_LO) begin
                state_nxt.rdData = state_r.settleGoal[7:0];
            end else if (regAddr == SETTLE_TARGET_D_HI) begin
                state_nxt.rdData = state_r.settleGoal[15:8];
            end else if (regAddr == EXT_OSC_SOURCE_ADDR) begin
                state_nxt.rdData = {7'h00, state_r.extOsc};
            end else if (regAddr == IO_LEVEL_CONFIG_ADDR) begin
                state_nxt.rdData = {7'h00, state_r.ioLevel};
            end else if (regAddr == INPUT_BUFFER_CONFIG_ADDR) begin
                state_nxt.rdData = state_r.inputCfg;
            end else if (regAddr == INPUT_DETECTOR_EN_ADDR) begin
                state_nxt.rdData = {4'h0, state_r.detectorCfg};
            end else if (regAddr == INPUT_HYSTERESIS_LO) begin
                state_nxt.rdData = state_r.hysteresis[7:0];
            end else if (regAddr == INPUT_HYSTERESIS_HI) begin
                // Upper nibble belongs to another field, reads zero
                state_nxt.rdData = {4'h0, state_r.hysteresis[HYST_W-1:8]};
            end else begin
                // Unmapped: answer zero so the host never sees junk
                state_nxt.rdData = 8'h00;
            end
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // Level select starts at 1.8 V so any host can reach the part
    always_ff @(posedge clk) begin
        if (reset) begin
            state_r.rampControl  <= RAMP_CONTROL_RST;
            state_r.ceilingOn    <= LOOP_LIMIT_RST[0];
            state_r.settleDetOn  <= LOOP_LIMIT_RST[1];
            state_r.iterationCap <= ITER_CAP_RST;
            state_r.settleGoal   <= SETTLE_GOAL_RST;
            state_r.extOsc       <= EXT_OSC_RST;
            state_r.ioLevel      <= IO_LEVEL_RST;
            state_r.inputCfg     <= INPUT_CFG_RST;
            state_r.detectorCfg  <= DETECTOR_EN_RST;
            state_r.hysteresis   <= HYST_RST;
            state_r.rdData       <= 8'h00;
            state_r.rdValid      <= 1'b0;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs, all straight from flip-flops
    // ----------------------------------------------------------------
    assign regRdData            = state_r.rdData;
    assign regRdValid           = state_r.rdValid;
    assign rampRateD            = cfgBus.rampRateD;
    // One bit ramps both switching and holdover or freerun entry
    assign inputSwitchRampedD   = state_r.rampControl[RAMP_SWITCH_BIT];
    assign holdoverEntryRampedD = state_r.rampControl[RAMP_SWITCH_BIT];
    assign outputCeilingOnD     = state_r.ceilingOn;
    assign settleDetectOnD      = state_r.settleDetOn;
    assign iterationCapD        = state_r.iterationCap;
    assign settleGoalD          = state_r.settleGoal;
    assign extOscSelect         = state_r.extOsc;
    assign ioLevel33            = state_r.ioLevel;
    assign inputBufferOn        = cfgBus.bufferOn;
    assign inputPulsedCmos      = cfgBus.pulsedCmos;
    assign inputToDetectorOn    = cfgBus.detectorOn;
    assign inputHysteresisCfg   = state_r.hysteresis;

endmodule // prcr_regs

/* File: tb/prcr_regs_asserts.sv */
// Concurrent checks on the ramp and input register bank ports.
// Assumes it is bound to prcr_regs and sees only its ports.
`timescale 1ns/1ns
module prcr_regs_asserts
    import prcr_pkg::*;
(
    input wire logic        clk,
    input wire logic        reset,
    input wire logic [15:0] regAddr,
    input wire logic        regWrEn,
    input wire logic [7:0]  regWrData,
    input wire logic        regRdEn,
    input wire logic [7:0]  regRdData,
    input wire logic        regRdValid,
    input wire logic [7:0]  baseRampRateD,
    input wire logic [19:0] rampRateD,
    input wire logic        inputSwitchRampedD,
    input wire logic        holdoverEntryRampedD,
    input wire logic        ioLevel33,
    input wire logic [3:0]  inputBufferOn,
    input wire logic [3:0]  inputPulsedCmos
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // ------------------------------------------------------------
    // Write decodes
    // ------------------------------------------------------------
    wire rampWr = regWrEn && regAddr == RAMP_CONTROL_D_ADDR;     // Ramp control write
    wire lvlWr  = regWrEn && regAddr == IO_LEVEL_CONFIG_ADDR;    // Level write
    wire bufWr  = regWrEn && regAddr == INPUT_BUFFER_CONFIG_ADDR; // Input config write
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    rd_valid_a: assert property (regRdEn |=> regRdValid)
        else $error("read not answered");
    rd_quiet_a: assert property (!regRdEn |=> !regRdValid)
        else $error("stray read valid");
    unmapped_zero_a: assert property (regRdEn && regAddr == 16'h0944 |=> regRdData == 8'h00)
        else $error("unmapped read not zero");
    level_reset_a: assert property ($fell(reset) |-> !ioLevel33)
        else $error("level not 1.8 V after reset");
    level_write_a: assert property (lvlWr |=> ioLevel33 == $past(regWrData[0]))
        else $error("level bit not taken");
    ramp_pair_a: assert property (rampWr |=> inputSwitchRampedD == $past(regWrData[3])
        && holdoverEntryRampedD == inputSwitchRampedD)
        else $error("ramp enable mismatch");
    buf_enable_a: assert property (bufWr |=> ##1 inputBufferOn == $past(regWrData[3:0], 2))
        else $error("buffer enables wrong");
    pulsed_sel_a: assert property (bufWr |=> ##1 inputPulsedCmos == $past(regWrData[7:4], 2))
        else $error("pulsed selects wrong");
    scale_max_a: assert property (rampWr && regWrData[2:0] == SCALE_X1024 ##1 !rampWr
        |=> rampRateD == {$past(baseRampRateD), 12'h000})
        else $error("1024x rate wrong");
    scale_quart_a: assert property (rampWr && regWrData[2:0] == SCALE_QUART ##1 !rampWr
        |=> rampRateD == {12'h000, $past(baseRampRateD)})
        else $error("quarter rate wrong");
endmodule // prcr_regs_asserts

bind prcr_regs prcr_regs_asserts i_chk (.*);

/* File: tb/prcr_host_model.sv */
// Management host model driving the byte strobe register port.
// Assumes the port takes strobes on the rising edge of clk.
`timescale 1ns/1ns
module prcr_host_model
    import prcr_pkg::*;
(
    input  wire logic              clk,
    output logic      [ADDR_W-1:0] regAddr,
    output logic                   regWrEn,
    output logic      [DATA_W-1:0] regWrData,
    output logic                   regRdEn,
    input  wire logic [DATA_W-1:0] regRdData,
    input  wire logic              regRdValid
);
    // Idle bus; parked values are never mistaken for a request
    initial begin
        regAddr = 16'hFFFF;
        regWrEn = 1'b0;
        regWrData = 8'h00;
        regRdEn = 1'b0;
    end
    // One write strobe; data inverted once the strobe drops
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk) #1;
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(posedge clk) #1;
        regWrEn = 1'b0;
        regWrData = ~d;
    endtask
    // One read strobe; data taken when valid has landed
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk) #1;
        regAddr = a;
        regRdEn = 1'b1;
        @(posedge clk) #1;
        regRdEn = 1'b0;
        d = regRdValid ? regRdData : 8'hXX;
    endtask
    // Bring-up: level first so a 3.3 V host is heard cleanly
    task automatic init();
        wr(IO_LEVEL_CONFIG_ADDR, 8'h01);
        wr(EXT_OSC_SOURCE_ADDR, 8'h01);
    endtask
endmodule // prcr_host_model

/* File: tb/prcr_regs_bench.sv */
// Self-checking bench for the ramp and input register bank.
// Assumes the host model owns the register port on clk.
`timescale 1ns/1ns
module prcr_regs_bench
    import prcr_pkg::*;
;
    logic              clk, reset, regWrEn, regRdEn, regRdValid;
    logic [ADDR_W-1:0] regAddr;
    logic [7:0]        regWrData, regRdData, baseRampRateD, d;
    logic [RATE_W-1:0] rampRateD;
    logic              inputSwitchRampedD, holdoverEntryRampedD, extOscSelect, ioLevel33;
    logic [3:0]        inputBufferOn, inputPulsedCmos, inputToDetectorOn;
    logic              outputCeilingOnD, settleDetectOnD;
    logic [15:0]       iterationCapD, settleGoalD;
    logic [HYST_W-1:0] inputHysteresisCfg;
    int                err_total, total_checks;
    int unsigned       q[8] = '{4, 16, 64, 256, 1024, 4096, 1, 2}; // Factor in quarters

    prcr_regs i_dut (.*);
    prcr_host_model i_host (.*);

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Compare any result, widened to the rate width
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic t_reset();
        chk(ioLevel33, 0);
        i_host.rd(IO_LEVEL_CONFIG_ADDR, d);
        chk(d, 0);
        $display("reset test done");
    endtask
    task automatic t_init();
        i_host.init();
        chk(ioLevel33, 1);
        chk(extOscSelect, 1);
        i_host.rd(EXT_OSC_SOURCE_ADDR, d);
        chk(d, 8'h01);
        $display("init test done");
    endtask
    // Every step code, enable set, then cleared
    task automatic t_ramp();
        for (int c = 0; c < 8; c++) begin
            i_host.wr(RAMP_CONTROL_D_ADDR, {5'h01, c[2:0]});
            repeat (2) @(posedge clk);
            #1;
            chk(rampRateD, 20'(baseRampRateD * q[c]));
            chk({inputSwitchRampedD, holdoverEntryRampedD}, 2'h3);
            i_host.rd(RAMP_CONTROL_D_ADDR, d);
            chk(d, {5'h01, c[2:0]});
        end
        i_host.wr(RAMP_CONTROL_D_ADDR, 8'h00);
        chk({inputSwitchRampedD, holdoverEntryRampedD}, 2'h0);
        $display("ramp test done");
    endtask
    task automatic t_inputs();
        i_host.wr(INPUT_BUFFER_CONFIG_ADDR, 8'hA5);
        i_host.wr(INPUT_DETECTOR_EN_ADDR, 8'h0F);
        @(posedge clk) #1;
        chk(inputBufferOn, 4'h5);
        chk(inputPulsedCmos, 4'hA);
        chk(inputToDetectorOn, 4'h5);
        i_host.rd(INPUT_BUFFER_CONFIG_ADDR, d);
        chk(d, 8'hA5);
        i_host.wr(INPUT_HYSTERESIS_HI, 8'hFF);
        i_host.rd(INPUT_HYSTERESIS_HI, d);
        chk(d, 8'h0F);
        i_host.rd(16'h0944, d);
        chk(d, 8'h00);
        $display("input test done");
    endtask
    // Loop options, byte pairs of the wide fields, hysteresis low byte
    task automatic t_wide();
        i_host.wr(LOOP_LIMIT_CONFIG_D_ADDR, 8'hFF);
        i_host.rd(LOOP_LIMIT_CONFIG_D_ADDR, d);
        chk(d, 8'h09);
        chk({outputCeilingOnD, settleDetectOnD}, 2'h3);
        i_host.wr(ITERATION_LIMIT_D_LO, 8'h34);
        i_host.wr(ITERATION_LIMIT_D_HI, 8'h12);
        i_host.wr(SETTLE_TARGET_D_LO, 8'h78);
        i_host.wr(SETTLE_TARGET_D_HI, 8'h56);
        i_host.wr(INPUT_HYSTERESIS_LO, 8'hC3);
        chk(iterationCapD, 16'h1234);
        chk(settleGoalD, 16'h5678);
        // High nibble was left at F by the input test
        chk(inputHysteresisCfg, 12'hFC3);
        i_host.rd(SETTLE_TARGET_D_HI, d);
        chk(d, 8'h56);
        $display("wide test done");
    endtask
    task automatic final_report();
        $display("checks=%0d mismatches=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        reset = 1'b1;
        baseRampRateD = 8'h5B;
        repeat (5) @(posedge clk);
        #1 reset = 1'b0;
        t_reset();
        t_init();
        t_ramp();
        t_inputs();
        t_wide();
        final_report();
    end
    // Watchdog: whole run is under a hundred cycles
    initial begin
        #200000;
        err_total++;
        final_report();
    end
endmodule // prcr_regs_bench
